// >>> pfio_pkg.sv
// Overview of operation
// - Four field configurations: full, front off, rear off, front and rear off.
// - Mode pins decode 00 standard, 10 box, 01 back gauge, 11 both; pin 1 first.
// - Advance field interrupted starts dynamic muting and drives both mute outputs low.
// - Under muting the danger zone stays monitored until the 6 mm gap.
// - Once muting starts the protected field is held fixed at the pinch point.
// - While muting, upper segments are switched off ahead of the descending tool.
// - Stroke init high allows tests and full field; safety and mute outputs low.
// - Without a requested test for 2 minutes an internal test starts itself.
// - Safety outputs stay off for the whole internal self-test.
// - Setup input high disables protection, display on, status red, light off.
// - Reduced field stroke runs only after a rising edge on acknowledge.
// - Safety outputs high with the field clear, low with it broken.
// - Mute outputs high without dynamic muting, low while it is active.
// - In test status mode, setup and mute pins carry data exchange.
// - Active outputs get short low test pulses the load must ride through.
// - Inactive outputs get 40 us high pulses every 100 us to 3 ms.
// - A regular test checks for shorts between the outputs.
// - The receiver drives an emitter enable that switches the light source.
// - The receiver drives a separate sync signal setting emitter intensity.
// - An object in the detection zone turns both safety outputs off.
package pfio_pkg;

    localparam int CLOCK_MHZ = 250;
    localparam longint AUTO_TEST_S = 120;
    localparam longint AUTO_TEST_CYC = AUTO_TEST_S * CLOCK_MHZ * 1000000;
    localparam int AUTO_W = 36;
    localparam int SELF_TEST_US = 100;
    localparam int SELF_TEST_CYC = SELF_TEST_US * CLOCK_MHZ;
    localparam int ON_PULSE_US = 40;
    localparam int ON_PULSE_CYC = ON_PULSE_US * CLOCK_MHZ;
    localparam int OFF_PULSE_US = 1;
    localparam int OFF_PULSE_CYC = OFF_PULSE_US * CLOCK_MHZ;
    localparam int PULSE_GAP_US = 500;
    localparam int PULSE_GAP_CYC = PULSE_GAP_US * CLOCK_MHZ;
    localparam int CNT_W = 20;

    localparam int SEG_N = 8;
    localparam logic [7:0] SEG_ALL = 8'hff;
    localparam logic [7:0] SEG_FRONT = 8'h03;
    localparam logic [7:0] SEG_REAR = 8'hc0;

    localparam logic [1:0] FM_STANDARD = 2'h0;
    localparam logic [1:0] FM_BOX = 2'h2;
    localparam logic [1:0] FM_GAUGE = 2'h1;
    localparam logic [1:0] FM_BOX_GAUGE = 2'h3;

    localparam int OUT_N = 4;

    typedef enum logic {TS_RUN, TS_TEST} pfio_test_state_t;
    typedef enum logic {MS_IDLE, MS_MUTE} pfio_mute_state_t;

    typedef struct packed {
        logic stroke_init;
        logic setup_mode;
        logic acknowledge;
        logic field_mode_1;
        logic field_mode_2;
    } pfio_ctrl_t;

    typedef struct packed {
        logic safety_switch_out_a;
        logic safety_switch_out_b;
        logic muting_out_a;
        logic muting_out_b;
    } pfio_outs_t;

endpackage : pfio_pkg

// >>> pfio_controller.sv
`timescale 1ns/1ps
module pfio_controller #(
    parameter longint AUTO_TEST_CYCLES = pfio_pkg::AUTO_TEST_CYC,
    parameter int SELF_TEST_CYCLES = pfio_pkg::SELF_TEST_CYC,
    parameter int ON_PULSE_CYCLES = pfio_pkg::ON_PULSE_CYC,
    parameter int OFF_PULSE_CYCLES = pfio_pkg::OFF_PULSE_CYC,
    parameter int PULSE_GAP_CYCLES = pfio_pkg::PULSE_GAP_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic reset,
    // Controller pins, asynchronous
    input wire pfio_pkg::pfio_ctrl_t ctrl_pins,
    input wire logic [3:0] out_readback,
    // Image evaluation, same clock
    input wire logic field_clear,
    input wire logic advance_hit,
    input wire logic gap_reached,
    input wire logic [3:0] tool_segment,
    input wire logic [7:0] intensity,
    input wire logic [1:0] comm_tx,
    // Output pins
    output pfio_pkg::pfio_outs_t out_pins,
    output logic emitter_enable,
    output logic emitter_intensity_sync,
    // Status to evaluation and display
    output logic [7:0] segment_enable,
    output logic field_hold,
    output logic system_test,
    output logic [2:0] comm_rx,
    output logic display_on,
    output logic status_red,
    output logic short_fault
);
    import pfio_pkg::*;

    function automatic logic [7:0] mode_mask(input logic [1:0] mode);
        case (mode)
            FM_BOX: mode_mask = SEG_ALL & ~SEG_FRONT;
            FM_GAUGE: mode_mask = SEG_ALL & ~SEG_REAR;
            FM_BOX_GAUGE: mode_mask = SEG_ALL & ~(SEG_FRONT | SEG_REAR);
            default: mode_mask = SEG_ALL;
        endcase
    endfunction : mode_mask

    function automatic logic [7:0] tool_mask(input logic [3:0] row);
        logic [7:0] m;
        m = SEG_ALL;
        for (int i = 0; i < SEG_N; i++) begin
            if (4'(i) < row) begin
                m[i] = 1'b0;
            end
        end
        tool_mask = m;
    endfunction : tool_mask

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers
    pfio_ctrl_t ctrl_meta;
    pfio_ctrl_t ctrl_sync;
    logic [3:0] rb_meta;
    logic [3:0] rb_sync;

    always_ff @(posedge clock) begin
        ctrl_meta <= ctrl_pins;
        ctrl_sync <= ctrl_meta;
        rb_meta <= out_readback;
        rb_sync <= rb_meta;
    end

    logic init_prev;
    logic ack_prev;
    logic init_rise;
    logic ack_rise;

    always_ff @(posedge clock) begin
        if (reset) begin
            init_prev <= 1'b1;
            ack_prev <= 1'b0;
        end else begin
            init_prev <= ctrl_sync.stroke_init;
            ack_prev <= ctrl_sync.acknowledge;
        end
    end

    assign init_rise = ctrl_sync.stroke_init & ~init_prev;
    assign ack_rise = ctrl_sync.acknowledge & ~ack_prev;

    ////////////////////////////////////////////////////////////////////////
    // Self-test sequencing
    pfio_test_state_t test_state;
    logic [AUTO_W-1:0] auto_cnt;
    logic [CNT_W-1:0] test_cnt;
    logic auto_due;
    logic test_done;

    assign auto_due = (auto_cnt == AUTO_W'(AUTO_TEST_CYCLES - 1));
    assign test_done = (test_cnt == CNT_W'(SELF_TEST_CYCLES - 1));

    always_ff @(posedge clock) begin
        if (reset) begin
            test_state <= TS_TEST;
        end else begin
            case (test_state)
                TS_RUN: begin
                    if (init_rise || auto_due) begin
                        test_state <= TS_TEST;
                    end
                end
                TS_TEST: begin
                    if (test_done) begin
                        test_state <= TS_RUN;
                    end
                end
                default: test_state <= TS_TEST;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset || test_state == TS_TEST || init_rise) begin
            auto_cnt <= '0;
        end else begin
            auto_cnt <= auto_cnt + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || test_state == TS_RUN) begin
            test_cnt <= '0;
        end else begin
            test_cnt <= test_cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reduced field arming
    logic reduced_armed;

    always_ff @(posedge clock) begin
        if (reset) begin
            reduced_armed <= 1'b0;
        end else begin
            reduced_armed <= ack_rise | (reduced_armed & ~init_rise);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dynamic muting
    pfio_mute_state_t mute_state;
    logic gap_latched;
    logic run_ok;

    assign run_ok = (test_state == TS_RUN) & ~ctrl_sync.setup_mode
                  & ~ctrl_sync.stroke_init;

    always_ff @(posedge clock) begin
        if (reset) begin
            mute_state <= MS_IDLE;
        end else begin
            case (mute_state)
                MS_IDLE: begin
                    if (run_ok && advance_hit) begin
                        mute_state <= MS_MUTE;
                    end
                end
                MS_MUTE: begin
                    if (!run_ok) begin
                        mute_state <= MS_IDLE;
                    end
                end
                default: mute_state <= MS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (reset || mute_state == MS_IDLE) begin
            gap_latched <= 1'b0;
        end else if (gap_reached) begin
            gap_latched <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Segment selection
    logic [7:0] next_segment_enable;

    always_comb begin
        next_segment_enable = SEG_ALL;
        if (ctrl_sync.setup_mode) begin
            next_segment_enable = '0;
        end else if (!ctrl_sync.stroke_init) begin
            if (reduced_armed) begin
                next_segment_enable = mode_mask({ctrl_sync.field_mode_1,
                    ctrl_sync.field_mode_2});
            end
            if (mute_state == MS_MUTE) begin
                next_segment_enable = next_segment_enable
                    & tool_mask(tool_segment);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            segment_enable <= SEG_ALL;
            field_hold <= 1'b0;
        end else begin
            segment_enable <= next_segment_enable;
            field_hold <= (mute_state == MS_MUTE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Logical output levels
    logic safe_level;
    logic mute_level;
    logic [3:0] level;

    assign safe_level = run_ok & ~short_fault
                      & (field_clear | gap_latched);
    assign mute_level = (test_state == TS_TEST) ? 1'b0
                      : run_ok & (mute_state == MS_IDLE);

    always_comb begin
        if (test_state == TS_TEST) begin
            level = {2'b00, comm_tx};
        end else begin
            level = {safe_level, safe_level, mute_level, mute_level};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output test pulses
    logic [CNT_W-1:0] gap_cnt;
    logic [CNT_W-1:0] pulse_cnt;
    logic [1:0] pulse_idx;
    logic pulse_on;
    logic pulse_start;
    logic pulse_last;

    assign pulse_on = (pulse_cnt != '0);
    assign pulse_last = (pulse_cnt == CNT_W'(1));
    assign pulse_start = (gap_cnt == CNT_W'(PULSE_GAP_CYCLES - 1))
                       && (test_state == TS_RUN);

    always_ff @(posedge clock) begin
        if (reset || gap_cnt == CNT_W'(PULSE_GAP_CYCLES - 1)) begin
            gap_cnt <= '0;
        end else begin
            gap_cnt <= gap_cnt + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pulse_cnt <= '0;
            pulse_idx <= '0;
        end else if (pulse_start) begin
            pulse_idx <= pulse_idx + 1'b1;
            pulse_cnt <= level[3 - 2'(pulse_idx + 2'd1)]
                ? CNT_W'(OFF_PULSE_CYCLES)
                : CNT_W'(ON_PULSE_CYCLES);
        end else if (pulse_on) begin
            pulse_cnt <= pulse_cnt - 1'b1;
        end
    end

    logic [3:0] next_outs;
    logic [3:0] outs;

    always_comb begin
        next_outs = level;
        if (pulse_on && test_state == TS_RUN) begin
            next_outs[3 - pulse_idx] = ~level[3 - pulse_idx];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            outs <= '0;
        end else begin
            outs <= next_outs;
        end
    end

    assign out_pins = pfio_outs_t'(outs);

    always_ff @(posedge clock) begin
        if (reset) begin
            short_fault <= 1'b0;
        end else if (pulse_last && rb_sync[3 - pulse_idx] != outs[3 - pulse_idx]) begin
            short_fault <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Emitter, display and data exchange
    logic [7:0] pwm_cnt;

    always_ff @(posedge clock) begin
        if (reset) begin
            pwm_cnt <= '0;
            emitter_enable <= 1'b0;
            emitter_intensity_sync <= 1'b0;
        end else begin
            pwm_cnt <= pwm_cnt + 1'b1;
            emitter_enable <= ~ctrl_sync.setup_mode;
            emitter_intensity_sync <= (pwm_cnt < intensity);
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            system_test <= 1'b1;
            comm_rx <= '0;
            display_on <= 1'b0;
            status_red <= 1'b1;
        end else begin
            system_test <= (test_state == TS_TEST);
            comm_rx <= (test_state == TS_TEST)
                ? {ctrl_sync.setup_mode, ctrl_sync.field_mode_1,
                   ctrl_sync.field_mode_2} : 3'h0;
            display_on <= ctrl_sync.setup_mode;
            status_red <= ctrl_sync.setup_mode | ~safe_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_init_held;
        ctrl_sync.stroke_init [*2];
    endsequence

    sequence s_outs_low;
        out_pins.safety_switch_out_a == 1'b0 && out_pins.muting_out_a == 1'b0;
    endsequence

    a_init_outs_low: assert property (@(posedge clock) disable iff (reset)
        s_init_held ##0 !pulse_on && test_state == TS_RUN |=> s_outs_low)
        else $error("outputs not low with stroke init high");

    a_test_safety_off: assert property (@(posedge clock) disable iff (reset)
        test_state == TS_TEST |=> !out_pins.safety_switch_out_a
        && !out_pins.safety_switch_out_b)
        else $error("safety output on during self-test");

    a_mute_start_low: assert property (@(posedge clock) disable iff (reset)
        mute_state == MS_IDLE && run_ok && advance_hit && !auto_due
        ##1 !pulse_on [*2] |-> !out_pins.muting_out_a && !out_pins.muting_out_b)
        else $error("mute outputs not low after muting start");

    a_setup_light_off: assert property (@(posedge clock) disable iff (reset)
        ctrl_sync.setup_mode |=> !emitter_enable && display_on
        && segment_enable == '0)
        else $error("setup mode not applied");

    a_pair_equal: assert property (@(posedge clock) disable iff (reset)
        $past(!pulse_on) && test_state == TS_RUN && $past(test_state) == TS_RUN
        |-> out_pins.safety_switch_out_a == out_pins.safety_switch_out_b)
        else $error("safety pair differs outside test pulse");

    a_auto_test_start: assert property (@(posedge clock) disable iff (reset)
        test_state == TS_RUN && auto_due |=> test_state == TS_TEST)
        else $error("automatic self-test not started");

    a_ack_arms: assert property (@(posedge clock) disable iff (reset)
        !reduced_armed && !ack_rise |=> !reduced_armed)
        else $error("reduced field armed without acknowledge edge");

    a_on_pulse_len: assert property (@(posedge clock) disable iff (reset)
        pulse_start && !level[3 - 2'(pulse_idx + 2'd1)]
        |=> pulse_cnt == CNT_W'(ON_PULSE_CYCLES))
        else $error("on-test pulse length wrong");

    a_field_broken: assert property (@(posedge clock) disable iff (reset)
        run_ok && !field_clear && !gap_latched && !pulse_on
        |=> !out_pins.safety_switch_out_a)
        else $error("safety output on with field broken");

endmodule : pfio_controller

// >>> pfio_partner.sv
`timescale 1ns/1ps
module pfio_partner (
    // Requests from the bench
    input wire logic at_top,
    input wire logic setup_req,
    input wire logic [1:0] mode_req,
    input wire logic ack_req,
    input wire logic [3:0] short_mask,
    // Pins of the block
    input wire pfio_pkg::pfio_outs_t out_pins,
    output pfio_pkg::pfio_ctrl_t ctrl_pins,
    output logic [3:0] out_readback
);
    import pfio_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Controller pins; no override input is offered before the gap
    always_comb begin
        ctrl_pins.stroke_init = at_top;
        ctrl_pins.setup_mode = setup_req;
        ctrl_pins.acknowledge = ack_req;
        ctrl_pins.field_mode_1 = mode_req[1];
        ctrl_pins.field_mode_2 = mode_req[0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Output wires seen back, a mask bit models a shorted line
    assign out_readback = out_pins ^ short_mask;

endmodule : pfio_partner

// >>> pfio_controller_tb_top.sv
`timescale 1ns/1ps
module pfio_controller_tb_top;
    import pfio_pkg::*;

    logic clock, reset, at_top, setup_req, ack_req;
    logic field_clear, advance_hit, gap_reached;
    logic emitter_enable, emitter_intensity_sync, field_hold;
    logic system_test, display_on, status_red, short_fault;
    logic [1:0] mode_req, comm_tx;
    logic [3:0] short_mask, out_readback, tool_segment;
    logic [7:0] intensity, segment_enable;
    logic [2:0] comm_rx;
    pfio_ctrl_t ctrl_pins;
    pfio_outs_t out_pins;
    int n_fail = 0;
    int compares = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////
    pfio_partner partner_u (.at_top(at_top), .setup_req(setup_req),
        .mode_req(mode_req), .ack_req(ack_req), .short_mask(short_mask),
        .out_pins(out_pins), .ctrl_pins(ctrl_pins),
        .out_readback(out_readback));

    pfio_controller #(.AUTO_TEST_CYCLES(2000), .SELF_TEST_CYCLES(20),
        .ON_PULSE_CYCLES(8), .OFF_PULSE_CYCLES(4), .PULSE_GAP_CYCLES(40))
    dut_u (.clock(clock), .reset(reset), .ctrl_pins(ctrl_pins),
        .out_readback(out_readback), .field_clear(field_clear),
        .advance_hit(advance_hit), .gap_reached(gap_reached),
        .tool_segment(tool_segment), .intensity(intensity),
        .comm_tx(comm_tx), .out_pins(out_pins),
        .emitter_enable(emitter_enable),
        .emitter_intensity_sync(emitter_intensity_sync),
        .segment_enable(segment_enable), .field_hold(field_hold),
        .system_test(system_test), .comm_rx(comm_rx),
        .display_on(display_on), .status_red(status_red),
        .short_fault(short_fault));

    initial begin
        clock = 1'h0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            n_fail++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic complete_run;
        if (n_fail == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic idle(input int n);
        repeat (n) @(negedge clock);
    endtask : idle

    // Level must hold for at least 4 of 12 samples; test pulses are short
    task automatic steady(input string name, input logic [3:0] exp);
        int hits = 0;
        repeat (12) begin
            @(negedge clock);
            if (out_pins === exp) hits++;
        end
        check(name, hits >= 4, 1'h1);
    endtask : steady

    task automatic test_done;
        int n = 0;
        while (system_test !== 1'h0 && n < 100) begin
            @(negedge clock);
            n++;
        end
        check("test end", n < 100, 1'h1);
    endtask : test_done

    task automatic raise_top;
        at_top = 1'h1;
        idle(6);
        test_done();
        at_top = 1'h0;
    endtask : raise_top

    ////////////////////////////////////////////////////////////////////////
    task automatic t_powerup;
        idle(3);
        check("test state", system_test, 1'h1);
        idle(4);
        check("test outs", out_pins, 4'h2);
        check("comm rx", comm_rx, 3'h1);
        test_done();
        steady("top outs", 4'h0);
    endtask : t_powerup

    task automatic t_run;
        int hi = 0;
        at_top = 1'h0;
        mode_req = 2'h0;
        idle(8);
        steady("clear outs", 4'hf);
        field_clear = 1'h0;
        idle(6);
        steady("broken outs", 4'h3);
        field_clear = 1'h1;
        repeat (256) begin
            @(negedge clock);
            if (emitter_intensity_sync === 1'h1) hi++;
        end
        check("sync duty", hi, 32'h0000_0040);
        check("light on", emitter_enable, 1'h1);
    endtask : t_run

    task automatic pulse_runs(input logic [3:0] base, input int exp_s);
        int run [4] = '{default: 0};
        int best [4] = '{default: 0};
        idle(8);
        repeat (200) begin
            @(negedge clock);
            for (int i = 0; i < 4; i++) begin
                run[i] = (out_pins[i] !== base[i]) ? run[i] + 1 : 0;
                if (run[i] > best[i]) best[i] = run[i];
            end
        end
        for (int i = 0; i < 4; i++) begin
            check("pulse run", best[i], (i > 1) ? exp_s : 4);
        end
    endtask : pulse_runs

    task automatic t_mute;
        comm_tx = 2'h0;
        advance_hit = 1'h1;
        idle(6);
        steady("mute outs", 4'hc);
        check("field hold", field_hold, 1'h1);
        tool_segment = 4'h3;
        idle(5);
        check("tool segs", segment_enable, 8'hf8);
        field_clear = 1'h0;
        idle(6);
        steady("mute broken", 4'h0);
        field_clear = 1'h1;
        gap_reached = 1'h1;
        idle(6);
        field_clear = 1'h0;
        idle(6);
        steady("gap override", 4'hc);
        at_top = 1'h1;
        idle(6);
        check("top test", system_test, 1'h1);
        steady("top off", 4'h0);
        advance_hit = 1'h0;
        gap_reached = 1'h0;
        tool_segment = 4'h0;
        field_clear = 1'h1;
        test_done();
        at_top = 1'h0;
    endtask : t_mute

    task automatic t_modes;
        logic [7:0] exp;
        for (int m = 0; m < 4; m++) begin
            mode_req = m[1:0];
            raise_top();
            idle(8);
            check("no ack segs", segment_enable, SEG_ALL);
            ack_req = 1'h1;
            idle(6);
            ack_req = 1'h0;
            idle(4);
            exp = SEG_ALL & ~(m[1] ? SEG_FRONT : 8'h00);
            exp = exp & ~(m[0] ? SEG_REAR : 8'h00);
            check("mode segs", segment_enable, exp);
        end
        mode_req = 2'h0;
    endtask : t_modes

    task automatic t_setup;
        setup_req = 1'h1;
        idle(6);
        check("setup light", emitter_enable, 1'h0);
        check("setup display", display_on, 1'h1);
        check("setup red", status_red, 1'h1);
        check("setup segs", segment_enable, 8'h00);
        steady("setup outs", 4'h0);
        setup_req = 1'h0;
        idle(6);
        check("light back", emitter_enable, 1'h1);
    endtask : t_setup

    task automatic t_auto;
        int n = 0;
        raise_top();
        while (system_test !== 1'h1 && n < 2500) begin
            @(negedge clock);
            n++;
        end
        check("auto test", n >= 1990 && n <= 2010, 1'h1);
        test_done();
    endtask : t_auto

    task automatic t_short;
        idle(8);
        check("no fault", short_fault, 1'h0);
        short_mask = 4'h4;
        idle(200);
        check("short found", short_fault, 1'h1);
        steady("short outs", 4'h3);
    endtask : t_short

    ////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'h1;
        at_top = 1'h1;
        setup_req = 1'h0;
        ack_req = 1'h0;
        mode_req = 2'h1;
        field_clear = 1'h1;
        advance_hit = 1'h0;
        gap_reached = 1'h0;
        tool_segment = 4'h0;
        intensity = 8'h40;
        comm_tx = 2'h2;
        short_mask = 4'h0;
        idle(3);
        check("reset outs", out_pins, 4'h0);
        check("reset segs", segment_enable, 8'hff);
        check("reset test", system_test, 1'h1);
        check("reset light", emitter_enable, 1'h0);
        reset = 1'h0;
        t_powerup();
        t_run();
        pulse_runs(4'hf, 4);
        field_clear = 1'h0;
        pulse_runs(4'h3, 8);
        field_clear = 1'h1;
        t_mute();
        t_modes();
        t_setup();
        t_auto();
        t_short();
        complete_run();
    end

endmodule : pfio_controller_tb_top
